//--- core/ocr_pkg.sv
`default_nettype none

package ocr_pkg;

    // register addresses as seen by the frame decoder
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_DATA = 8'h01;
    localparam logic [7:0] ADDR_CONTROL = 8'h55;
    localparam logic [7:0] ADDR_RESET = 8'h56;
    localparam logic [7:0] ADDR_CONFIG = 8'h57;
    localparam logic [7:0] ADDR_GAIN = 8'h58;
    localparam logic [7:0] ADDR_ZERO = 8'h59;

    // reset values
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] CONFIG_RESET = 16'h0000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [15:0] GAIN_RESET = 16'hFFFF;
    localparam logic [15:0] ZERO_RESET = 16'h0000;
    localparam logic [15:0] MIDSCALE_CODE = 16'h8000;

    // writable bits; reserved bits are stored as zero
    localparam logic [15:0] CONTROL_WRITE_MASK = 16'hFFF7;
    localparam logic [15:0] CONFIG_WRITE_MASK = 16'h07BF;

    // control register fields
    localparam int CTL_CLEAR_SEL = 15;
    localparam int CTL_OUT_EN = 12;
    localparam int CTL_RCLK_HI = 11;
    localparam int CTL_RCLK_LO = 8;
    localparam int CTL_RSTEP_HI = 7;
    localparam int CTL_RSTEP_LO = 5;
    localparam int CTL_SLEW_EN = 4;
    localparam int CTL_RANGE_HI = 2;
    localparam int CTL_RANGE_LO = 0;
    localparam int RANGE_CURRENT_BIT = 2;
    localparam int RANGE_BIPOLAR_BIT = 1;

    // configuration register fields
    localparam int CFG_SPAN_HI = 10;
    localparam int CFG_SPAN_LO = 9;
    localparam int CFG_BOTH_EN = 8;
    localparam int CFG_ALT_PD = 7;
    localparam int CFG_TRIM_EN = 5;
    localparam int CFG_MODEM_EN = 4;
    localparam int CFG_FRAME_CHK = 3;
    localparam int CFG_WD_EN = 2;
    localparam int CFG_WD_SEL_HI = 1;
    localparam int CFG_WD_SEL_LO = 0;

    // reset register and status bits
    localparam int RST_BIT = 0;
    localparam int ST_FRAME_ERR = 4;
    localparam int ST_WATCHDOG = 3;
    localparam int ST_LOAD = 2;
    localparam int ST_RAMP = 1;
    localparam int ST_OVERTEMP = 0;

    // range codes
    localparam logic [2:0] RANGE_4_20MA = 3'b101;

    // timing
    localparam int CLK_HZ = 100_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int WD_MS0 = 10;
    localparam int WD_MS1 = 50;
    localparam int WD_MS2 = 100;
    localparam int WD_MS3 = 200;

endpackage

`default_nettype wire

//--- core/ocr_trim.sv
`timescale 1ns/1ps
`default_nettype none

// code_out = code * (gain + 1) / 65536 + zero, clamped to the code range
module ocr_trim #(
    parameter int DATA_BITS = 16
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic trim_enable,
    input wire logic [15:0] code_in,
    input wire logic [15:0] gain,
    input wire logic [15:0] zero,
    output logic [15:0] code_out
);

    localparam logic [15:0] LOW_MASK = 16'((32'h1 << (16 - DATA_BITS)) - 32'h1);

    logic [16:0] gain_p1;
    logic [32:0] product;
    logic signed [17:0] scaled;
    logic signed [17:0] sum;
    logic [15:0] trimmed;

    // gain is unsigned, zero is twos complement
    assign gain_p1 = {1'b0, gain} + 17'h00001;
    assign product = 33'(code_in) * 33'(gain_p1);
    assign scaled = $signed({1'b0, product[32:16]});
    assign sum = scaled + 18'($signed(zero));

    always_comb begin
        if (sum < 18'sh00000) begin
            trimmed = 16'h0000;
        end else if (sum > 18'sh0FFFF) begin
            trimmed = 16'hFFFF;
        end else begin
            trimmed = sum[15:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            code_out <= 16'h0000;
        end else if (trim_enable) begin
            code_out <= trimmed & ~LOW_MASK;
        end else begin
            code_out <= code_in & ~LOW_MASK;
        end
    end

endmodule

`default_nettype wire

//--- core/ocr_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// - secondary span used only in dual mode
// - secondary span decodes like range with top set
// - secondary span write keeps output code
// - dual enable drives both outputs, one code
// - alternate powerdown pulls sense node to ground
// - trim enable applies gain and zero trims
// - modem input only in 4-20 mA range
// - frame checking only when enabled
// - output code unsigned, resets to zero
// - 12-bit variant ignores low four bits
// - gain trim is unsigned sixteen bits
// - zero trim is signed sixteen bits
// - reset bit restores power-on defaults, except input synchronizers, read data and trim output register
// - reset bit clears itself
// - monitored faults set alarm flags; only frame and watchdog flags hold
// - flags clear on reset or fault resolution
// - status bit four flags frame error
// - status bit three flags watchdog timeout
// - status bit two flags load fault
// - status bit one shows ramping
// - status bit zero flags overtemperature
// - primary range selects output when enabled
module ocr_regs #(
    parameter int DATA_BITS = 16,
    parameter int WD_CYC0 = ocr_pkg::WD_MS0 * ocr_pkg::CYC_PER_MS,
    parameter int WD_CYC1 = ocr_pkg::WD_MS1 * ocr_pkg::CYC_PER_MS,
    parameter int WD_CYC2 = ocr_pkg::WD_MS2 * ocr_pkg::CYC_PER_MS,
    parameter int WD_CYC3 = ocr_pkg::WD_MS3 * ocr_pkg::CYC_PER_MS
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_addr,
    input wire logic [15:0] reg_wr_data,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_rd_addr,
    output logic [15:0] reg_rd_data,
    output logic reg_rd_valid,
    input wire logic frame_crc_bad,
    input wire logic frame_fault_clear,
    input wire logic watchdog_kick,
    input wire logic load_fault_in,
    input wire logic overtemp_in,
    output logic frame_check_active,
    output logic voltage_output_enable,
    output logic current_output_enable,
    output logic [2:0] voltage_span,
    output logic [2:0] current_span,
    output logic sense_pulldown_enable,
    output logic modem_couple_enable,
    output logic [15:0] output_code,
    output logic [15:0] alarm_flags
);

    localparam logic [15:0] LOW_MASK = 16'((32'h1 << (16 - DATA_BITS)) - 32'h1);

    logic [15:0] control_r;
    logic [15:0] configuration_r;
    logic [15:0] output_code_r;
    logic [15:0] gain_trim_r;
    logic [15:0] zero_trim_r;
    logic soft_reset_r;
    logic regs_reset;
    logic [1:0] load_sync_r;
    logic [1:0] temp_sync_r;
    logic frame_error_flag_r;
    logic watchdog_timeout_flag_r;
    logic load_fault_flag_r;
    logic ramping_flag_r;
    logic overtemp_flag_r;
    logic [31:0] wd_count_r;
    logic [31:0] wd_limit;
    logic [15:0] ramp_div_r;
    logic [15:0] ramp_code_r;
    logic [15:0] ramp_code_nxt;
    logic [15:0] ramp_step;
    logic [15:0] ramp_gap;
    logic ramp_tick;
    logic [15:0] clear_code;
    logic [2:0] primary_range;
    logic [1:0] secondary_current_span;
    logic both_outputs_enable;
    logic output_enable_bit;
    logic slew_enable;
    logic [3:0] ramp_clock_select;
    logic [2:0] ramp_step_select;
    logic watchdog_enable;
    logic [1:0] watchdog_period_select;
    logic wr_control;
    logic range_changed;

    assign primary_range = control_r[ocr_pkg::CTL_RANGE_HI:ocr_pkg::CTL_RANGE_LO];
    assign output_enable_bit = control_r[ocr_pkg::CTL_OUT_EN];
    assign slew_enable = control_r[ocr_pkg::CTL_SLEW_EN];
    assign ramp_clock_select = control_r[ocr_pkg::CTL_RCLK_HI:ocr_pkg::CTL_RCLK_LO];
    assign ramp_step_select = control_r[ocr_pkg::CTL_RSTEP_HI:ocr_pkg::CTL_RSTEP_LO];
    assign secondary_current_span = configuration_r[ocr_pkg::CFG_SPAN_HI:ocr_pkg::CFG_SPAN_LO];
    assign both_outputs_enable = configuration_r[ocr_pkg::CFG_BOTH_EN];
    assign watchdog_enable = configuration_r[ocr_pkg::CFG_WD_EN];
    assign watchdog_period_select = configuration_r[ocr_pkg::CFG_WD_SEL_HI:ocr_pkg::CFG_WD_SEL_LO];

    assign regs_reset = !resetn || soft_reset_r;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            soft_reset_r <= 1'b0;
        end else begin
            soft_reset_r <= reg_wr_en && (reg_wr_addr == ocr_pkg::ADDR_RESET) &&
                            reg_wr_data[ocr_pkg::RST_BIT] && !soft_reset_r;
        end
    end

    assign wr_control = reg_wr_en && (reg_wr_addr == ocr_pkg::ADDR_CONTROL);
    assign range_changed = wr_control &&
        (reg_wr_data[ocr_pkg::CTL_RANGE_HI:ocr_pkg::CTL_RANGE_LO] != primary_range);

    always_ff @(posedge clock) begin
        if (regs_reset) begin
            control_r <= ocr_pkg::CONTROL_RESET;
        end else if (wr_control) begin
            control_r <= reg_wr_data & ocr_pkg::CONTROL_WRITE_MASK;
        end
    end

    always_ff @(posedge clock) begin
        if (regs_reset) begin
            configuration_r <= ocr_pkg::CONFIG_RESET;
        end else if (reg_wr_en && (reg_wr_addr == ocr_pkg::ADDR_CONFIG)) begin
            configuration_r <= reg_wr_data & ocr_pkg::CONFIG_WRITE_MASK;
        end
    end

    // clear value follows the new range: 0 V, or midscale / negative full scale
    always_comb begin
        if (reg_wr_data[ocr_pkg::RANGE_CURRENT_BIT]) begin
            clear_code = ocr_pkg::DATA_RESET;
        end else if (reg_wr_data[ocr_pkg::RANGE_BIPOLAR_BIT] ^ reg_wr_data[ocr_pkg::CTL_CLEAR_SEL]) begin
            clear_code = ocr_pkg::MIDSCALE_CODE;
        end else begin
            clear_code = ocr_pkg::DATA_RESET;
        end
    end

    always_ff @(posedge clock) begin
        if (regs_reset) begin
            output_code_r <= ocr_pkg::DATA_RESET;
        end else if (range_changed) begin
            output_code_r <= clear_code;
        end else if (reg_wr_en && (reg_wr_addr == ocr_pkg::ADDR_DATA)) begin
            output_code_r <= reg_wr_data & ~LOW_MASK;
        end
    end

    always_ff @(posedge clock) begin
        if (regs_reset) begin
            gain_trim_r <= ocr_pkg::GAIN_RESET & ~LOW_MASK;
        end else if (reg_wr_en && (reg_wr_addr == ocr_pkg::ADDR_GAIN)) begin
            gain_trim_r <= reg_wr_data & ~LOW_MASK;
        end
    end

    always_ff @(posedge clock) begin
        if (regs_reset) begin
            zero_trim_r <= ocr_pkg::ZERO_RESET;
        end else if (reg_wr_en && (reg_wr_addr == ocr_pkg::ADDR_ZERO)) begin
            zero_trim_r <= reg_wr_data & ~LOW_MASK;
        end
    end

    // analog comparators are asynchronous to clock
    always_ff @(posedge clock) begin
        if (!resetn) begin
            load_sync_r <= 2'b00;
            temp_sync_r <= 2'b00;
        end else begin
            load_sync_r <= {load_sync_r[0], load_fault_in};
            temp_sync_r <= {temp_sync_r[0], overtemp_in};
        end
    end

    // load fault only counts while current drives
    always_ff @(posedge clock) begin
        if (regs_reset) begin
            load_fault_flag_r <= 1'b0;
            overtemp_flag_r <= 1'b0;
        end else begin
            load_fault_flag_r <= load_sync_r[1] && current_output_enable;
            overtemp_flag_r <= temp_sync_r[1];
        end
    end

    // frame error, set wins over clear
    always_ff @(posedge clock) begin
        if (regs_reset) begin
            frame_error_flag_r <= 1'b0;
        end else if (frame_check_active && frame_crc_bad) begin
            frame_error_flag_r <= 1'b1;
        end else if (frame_fault_clear) begin
            frame_error_flag_r <= 1'b0;
        end
    end

    always_comb begin
        case (watchdog_period_select)
            2'b00: wd_limit = 32'(WD_CYC0);
            2'b01: wd_limit = 32'(WD_CYC1);
            2'b10: wd_limit = 32'(WD_CYC2);
            default: wd_limit = 32'(WD_CYC3);
        endcase
    end

    always_ff @(posedge clock) begin
        if (regs_reset || !watchdog_enable || watchdog_kick) begin
            wd_count_r <= 32'h0000_0000;
        end else if (wd_count_r < wd_limit) begin
            wd_count_r <= wd_count_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge clock) begin
        if (regs_reset) begin
            watchdog_timeout_flag_r <= 1'b0;
        end else if (watchdog_enable && (wd_count_r >= wd_limit) && !watchdog_kick) begin
            watchdog_timeout_flag_r <= 1'b1;
        end else if (watchdog_kick) begin
            watchdog_timeout_flag_r <= 1'b0;
        end
    end

    // ramp tick every 2^select cycles, step of 2^select codes
    assign ramp_tick = (ramp_div_r == 16'((32'h1 << ramp_clock_select) - 32'h1));
    assign ramp_step = 16'(32'h1 << ramp_step_select);

    always_ff @(posedge clock) begin
        if (regs_reset || !slew_enable || ramp_tick) begin
            ramp_div_r <= 16'h0000;
        end else begin
            ramp_div_r <= ramp_div_r + 16'h0001;
        end
    end

    always_comb begin
        ramp_gap = 16'h0000;
        ramp_code_nxt = ramp_code_r;
        if (!slew_enable) begin
            ramp_code_nxt = output_code_r;
        end else if (ramp_tick) begin
            if (output_code_r > ramp_code_r) begin
                ramp_gap = output_code_r - ramp_code_r;
                ramp_code_nxt = (ramp_gap <= ramp_step) ? output_code_r : ramp_code_r + ramp_step;
            end else if (output_code_r < ramp_code_r) begin
                ramp_gap = ramp_code_r - output_code_r;
                ramp_code_nxt = (ramp_gap <= ramp_step) ? output_code_r : ramp_code_r - ramp_step;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (regs_reset) begin
            ramp_code_r <= ocr_pkg::DATA_RESET;
            ramping_flag_r <= 1'b0;
        end else begin
            ramp_code_r <= ramp_code_nxt;
            ramping_flag_r <= slew_enable && (ramp_code_nxt != output_code_r);
        end
    end

    ocr_trim #(
        .DATA_BITS(DATA_BITS)
    ) u_trim (
        .clock(clock),
        .resetn(resetn),
        .trim_enable(configuration_r[ocr_pkg::CFG_TRIM_EN]),
        .code_in(ramp_code_r),
        .gain(gain_trim_r),
        .zero(zero_trim_r),
        .code_out(output_code)
    );

    assign frame_check_active = configuration_r[ocr_pkg::CFG_FRAME_CHK];
    assign voltage_span = primary_range;

    always_ff @(posedge clock) begin
        if (regs_reset) begin
            voltage_output_enable <= 1'b0;
            current_output_enable <= 1'b0;
            current_span <= 3'b000;
            sense_pulldown_enable <= 1'b0;
            modem_couple_enable <= 1'b0;
        end else begin
            voltage_output_enable <= output_enable_bit &&
                (both_outputs_enable || !primary_range[ocr_pkg::RANGE_CURRENT_BIT]);
            current_output_enable <= output_enable_bit &&
                (both_outputs_enable || primary_range[ocr_pkg::RANGE_CURRENT_BIT]);
            current_span <= both_outputs_enable ? {1'b1, secondary_current_span} : primary_range;
            sense_pulldown_enable <= configuration_r[ocr_pkg::CFG_ALT_PD];
            modem_couple_enable <= configuration_r[ocr_pkg::CFG_MODEM_EN] && output_enable_bit &&
                ((both_outputs_enable ? {1'b1, secondary_current_span} : primary_range) ==
                 ocr_pkg::RANGE_4_20MA);
        end
    end

    always_comb begin
        alarm_flags = 16'h0000;
        alarm_flags[ocr_pkg::ST_FRAME_ERR] = frame_error_flag_r;
        alarm_flags[ocr_pkg::ST_WATCHDOG] = watchdog_timeout_flag_r;
        alarm_flags[ocr_pkg::ST_LOAD] = load_fault_flag_r;
        alarm_flags[ocr_pkg::ST_RAMP] = ramping_flag_r;
        alarm_flags[ocr_pkg::ST_OVERTEMP] = overtemp_flag_r;
    end

    // reads answer one cycle later; unmapped and reset register read zero
    always_ff @(posedge clock) begin
        if (!resetn) begin
            reg_rd_data <= 16'h0000;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) begin
                case (reg_rd_addr)
                    ocr_pkg::ADDR_STATUS: reg_rd_data <= alarm_flags;
                    ocr_pkg::ADDR_DATA: reg_rd_data <= output_code_r;
                    ocr_pkg::ADDR_CONTROL: reg_rd_data <= control_r;
                    ocr_pkg::ADDR_CONFIG: reg_rd_data <= configuration_r;
                    ocr_pkg::ADDR_GAIN: reg_rd_data <= gain_trim_r;
                    ocr_pkg::ADDR_ZERO: reg_rd_data <= zero_trim_r;
                    default: reg_rd_data <= 16'h0000;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

//--- testbench/ocr_host.sv
`timescale 1ns/1ps
`default_nettype none
module ocr_host (
    input wire logic clock,
    output var logic reg_wr_en,
    output var logic [7:0] reg_wr_addr,
    output var logic [15:0] reg_wr_data,
    output var logic reg_rd_en,
    output var logic [7:0] reg_rd_addr
);
    initial begin
        reg_wr_en = 1'b0;
        reg_wr_addr = 8'hFF;
        reg_wr_data = 16'h0000;
        reg_rd_en = 1'b0;
        reg_rd_addr = 8'hFF;
    end
    // released lines show the inverse so a stale value is never mistaken for a live one
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr_en <= 1'b1;
        reg_wr_addr <= a;
        reg_wr_data <= (a == ocr_pkg::ADDR_CONFIG) ? (d & 16'h07BF) : d;
        @(posedge clock);
        reg_wr_en <= 1'b0;
        reg_wr_addr <= ~a;
        reg_wr_data <= ~d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_rd_en <= 1'b1;
        reg_rd_addr <= a;
        @(posedge clock);
        reg_rd_en <= 1'b0;
        reg_rd_addr <= ~a;
    endtask
endmodule
`default_nettype wire

//--- testbench/ocr_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ocr_chk (
    input wire logic clock,
    input wire logic resetn,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_addr,
    input wire logic [15:0] reg_wr_data,
    input wire logic frame_crc_bad,
    input wire logic frame_fault_clear,
    input wire logic watchdog_kick,
    input wire logic load_fault_in,
    input wire logic overtemp_in,
    input wire logic frame_check_active,
    input wire logic current_output_enable,
    input wire logic sense_pulldown_enable,
    input wire logic [15:0] alarm_flags
);
    logic sr_q;
    logic sr_qq;
    // state snaps to defaults one edge after a reset write; attempts that straddle or start
    // on that edge mix pre- and post-reset values, so the relations pause for two edges
    always_ff @(posedge clock) begin
        sr_q <= resetn && reg_wr_en && reg_wr_addr == ocr_pkg::ADDR_RESET && reg_wr_data[ocr_pkg::RST_BIT];
        sr_qq <= sr_q;
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn || sr_q || sr_qq);
    sequence s_cfg_wr;
        reg_wr_en && reg_wr_addr == ocr_pkg::ADDR_CONFIG;
    endsequence
    sequence s_bad_frame;
        frame_check_active && frame_crc_bad;
    endsequence
    a_frame_set: assert property (s_bad_frame |=> alarm_flags[4])
        else $error("frame error flag not set");
    a_frame_gate: assert property (!frame_check_active && !alarm_flags[4] |=> !alarm_flags[4])
        else $error("frame error flag set while checking off");
    a_frame_clear: assert property (frame_fault_clear && !(frame_check_active && frame_crc_bad)
        |=> !alarm_flags[4])
        else $error("frame error flag not cleared");
    a_frame_hold: assert property (alarm_flags[4] && !frame_fault_clear |=> alarm_flags[4])
        else $error("frame error flag dropped");
    a_cfg_check: assert property (s_cfg_wr |=> frame_check_active == $past(reg_wr_data[3]))
        else $error("frame check enable does not follow config");
    a_alt_pd: assert property (s_cfg_wr ##1 1'b1 |=> sense_pulldown_enable == $past(reg_wr_data[7], 2))
        else $error("sense pulldown does not follow config");
    a_temp_on: assert property (overtemp_in [*4] |-> alarm_flags[0])
        else $error("overtemp flag missing");
    a_temp_off: assert property (!overtemp_in [*4] |-> !alarm_flags[0])
        else $error("overtemp flag stuck");
    a_load_on: assert property ((load_fault_in && current_output_enable) [*4] |-> alarm_flags[2])
        else $error("load fault flag missing");
    a_kick_clear: assert property (watchdog_kick |=> !alarm_flags[3])
        else $error("watchdog flag not cleared by kick");
    a_soft_clear: assert property (disable iff (!resetn)
        sr_q |=> (!frame_check_active && alarm_flags[4:3] == 2'b00) ##1 !sense_pulldown_enable)
        else $error("soft reset left state behind");
endmodule
bind ocr_regs ocr_chk u_chk (.clock(clock), .resetn(resetn), .reg_wr_en(reg_wr_en),
    .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .frame_crc_bad(frame_crc_bad),
    .frame_fault_clear(frame_fault_clear), .watchdog_kick(watchdog_kick), .load_fault_in(load_fault_in),
    .overtemp_in(overtemp_in), .frame_check_active(frame_check_active),
    .current_output_enable(current_output_enable), .sense_pulldown_enable(sense_pulldown_enable),
    .alarm_flags(alarm_flags));
`default_nettype wire

//--- testbench/output_dac_config_status_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module output_dac_config_status_regs_tb;
    logic clock, resetn, load_in, temp_in, reg_wr_en, reg_rd_en, reg_rd_valid, fchk, v_en, i_en, spd, modem;
    logic [2:0] ev, v_span, i_span;
    logic [7:0] reg_wr_addr, reg_rd_addr;
    logic [15:0] reg_wr_data, reg_rd_data, code, flags;
    logic [15:0] exp_q[$];
    logic [31:0] seed = 32'h29D2B9ED;
    int err_total = 0;
    int n_checks = 0;
    // short watchdog periods keep the run brief
    ocr_regs #(.DATA_BITS(16), .WD_CYC0(20), .WD_CYC1(40), .WD_CYC2(60), .WD_CYC3(80)) u_dut (
        .clock(clock), .resetn(resetn), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_addr(reg_rd_addr),
        .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .frame_crc_bad(ev[0]),
        .frame_fault_clear(ev[1]), .watchdog_kick(ev[2]), .load_fault_in(load_in), .overtemp_in(temp_in),
        .frame_check_active(fchk), .voltage_output_enable(v_en), .current_output_enable(i_en),
        .voltage_span(v_span), .current_span(i_span), .sense_pulldown_enable(spd),
        .modem_couple_enable(modem), .output_code(code), .alarm_flags(flags));
    ocr_host u_host (.clock(clock), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_addr(reg_rd_addr));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rdx(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        u_host.rd(a);
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic rnd16(output logic [15:0] v);
        seed = lfsr_next(seed);
        v = seed[15:0];
    endtask
    task automatic pulse(input logic [2:0] p);
        @(posedge clock);
        ev <= p;
        @(posedge clock);
        ev <= 3'b000;
    endtask
    // sample one step after the edge so the design's updates have landed
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clock) begin
        if (reg_rd_valid === 1'b1) begin
            if (exp_q.size() == 0)
                chk("unexpected read", 16'hFFFF, reg_rd_data);
            else
                chk("read data", exp_q.pop_front(), reg_rd_data);
        end
    end
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        give_verdict();
    end
    initial begin
        logic [15:0] v;
        resetn = 1'b0;
        ev = 3'b000;
        load_in = 1'b0;
        temp_in = 1'b0;
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        rdx(ocr_pkg::ADDR_STATUS, 16'h0000);
        rdx(ocr_pkg::ADDR_DATA, 16'h0000);
        rdx(ocr_pkg::ADDR_CONFIG, 16'h0000);
        rdx(ocr_pkg::ADDR_GAIN, ocr_pkg::GAIN_RESET);
        rdx(ocr_pkg::ADDR_ZERO, 16'h0000);
        rdx(8'h3C, 16'h0000);
        $display("test reset_values done");
        for (int i = 0; i < 4; i++) begin
            rnd16(v);
            u_host.wr(ocr_pkg::ADDR_CONFIG, v);
            step(2);
            chk("frame_check_active", v[3], fchk);
            chk("sense_pulldown", v[7], spd);
            rdx(ocr_pkg::ADDR_CONFIG, v & 16'h07BF);
            rnd16(v);
            u_host.wr(ocr_pkg::ADDR_GAIN, v);
            rdx(ocr_pkg::ADDR_GAIN, v);
            rnd16(v);
            u_host.wr(ocr_pkg::ADDR_ZERO, v);
            rdx(ocr_pkg::ADDR_ZERO, v);
        end
        $display("test config_random done");
        // trim may be left on by the random configurations
        u_host.wr(ocr_pkg::ADDR_CONFIG, 16'h0000);
        rnd16(v);
        u_host.wr(ocr_pkg::ADDR_CONTROL, 16'h1002);
        u_host.wr(ocr_pkg::ADDR_DATA, v);
        step(2);
        chk("output_code", v, code);
        for (int s = 0; s < 4; s++) begin
            u_host.wr(ocr_pkg::ADDR_CONFIG, {5'h00, s[1:0], 9'h100});
            step(2);
            chk("current_span", {1'b1, s[1:0]}, i_span);
            chk("voltage_span", 3'b010, v_span);
            chk("both_enables", 2'b11, {v_en, i_en});
            rdx(ocr_pkg::ADDR_DATA, v);
        end
        u_host.wr(ocr_pkg::ADDR_CONFIG, 16'h0600);
        step(2);
        chk("current_span", 3'b010, i_span);
        u_host.wr(ocr_pkg::ADDR_CONFIG, 16'h0010);
        for (int m = 0; m < 2; m++) begin
            u_host.wr(ocr_pkg::ADDR_CONTROL, (m == 0) ? 16'h1006 : 16'h1005);
            step(3);
            chk("modem_couple", m == 1, modem);
        end
        $display("test outputs done");
        u_host.wr(ocr_pkg::ADDR_CONFIG, 16'h0000);
        pulse(3'b110);
        pulse(3'b001);
        rdx(ocr_pkg::ADDR_STATUS, 16'h0000);
        u_host.wr(ocr_pkg::ADDR_CONFIG, 16'h0008);
        pulse(3'b001);
        rdx(ocr_pkg::ADDR_STATUS, 16'h0010);
        rdx(ocr_pkg::ADDR_STATUS, 16'h0010);
        pulse(3'b010);
        rdx(ocr_pkg::ADDR_STATUS, 16'h0000);
        @(posedge clock);
        load_in <= 1'b1;
        temp_in <= 1'b1;
        step(5);
        rdx(ocr_pkg::ADDR_STATUS, 16'h0005);
        @(posedge clock);
        load_in <= 1'b0;
        temp_in <= 1'b0;
        step(5);
        rdx(ocr_pkg::ADDR_STATUS, 16'h0000);
        u_host.wr(ocr_pkg::ADDR_CONFIG, 16'h0004);
        step(30);
        rdx(ocr_pkg::ADDR_STATUS, 16'h0008);
        u_host.wr(ocr_pkg::ADDR_CONFIG, 16'h0007);
        pulse(3'b100);
        step(40);
        rdx(ocr_pkg::ADDR_STATUS, 16'h0000);
        step(60);
        rdx(ocr_pkg::ADDR_STATUS, 16'h0008);
        $display("test alarms done");
        u_host.wr(ocr_pkg::ADDR_CONFIG, 16'h0000);
        pulse(3'b100);
        u_host.wr(ocr_pkg::ADDR_CONTROL, 16'h1010);
        u_host.wr(ocr_pkg::ADDR_DATA, 16'h0040);
        rdx(ocr_pkg::ADDR_STATUS, 16'h0002);
        step(120);
        rdx(ocr_pkg::ADDR_STATUS, 16'h0000);
        chk("output_code", 16'h0040, code);
        u_host.wr(ocr_pkg::ADDR_GAIN, 16'h7FFF);
        u_host.wr(ocr_pkg::ADDR_ZERO, 16'hFFF0);
        u_host.wr(ocr_pkg::ADDR_CONFIG, 16'h0020);
        step(4);
        chk("trimmed_code", 16'h0010, code);
        $display("test ramp_trim done");
        u_host.wr(ocr_pkg::ADDR_RESET, 16'h0001);
        step(3);
        rdx(ocr_pkg::ADDR_CONFIG, 16'h0000);
        rdx(ocr_pkg::ADDR_GAIN, ocr_pkg::GAIN_RESET);
        rdx(ocr_pkg::ADDR_DATA, 16'h0000);
        rdx(ocr_pkg::ADDR_RESET, 16'h0000);
        u_host.wr(ocr_pkg::ADDR_CONFIG, 16'h0008);
        rdx(ocr_pkg::ADDR_CONFIG, 16'h0008);
        step(4);
        chk("output_code", 16'h0000, code);
        chk("pending reads", 16'h0000, 16'(exp_q.size()));
        $display("test soft_reset done");
        give_verdict();
    end
endmodule
`default_nettype wire
